// [logic/i2c_ctrl_defs.svh]
// constants of the i2c bus mode controller: offsets, field positions, counts
`ifndef I2C_CTRL_DEFS_SVH
`define I2C_CTRL_DEFS_SVH

// ====================================================================
// register indices, byte address is four times the index
`define IDX_CONTROL_ONE 2'h0
`define IDX_DATA_BUFFER 2'h1
`define IDX_OWN_ADDRESS 2'h2
`define IDX_CONTROL_TWO 2'h3
`define HSIZE_WORD 3'h2

// ====================================================================
// control_two / status_reg field positions
`define CR2_MST 7
`define CR2_TRX 6
`define CR2_BB 5
`define CR2_PIN 4
`define CR2_SBIM_HI 3
`define CR2_SBIM_LO 2
// control_one field positions
`define CR1_BC_HI 7
`define CR1_BC_LO 5
`define CR1_ACK 4
`define CR1_SCK_HI 2
`define CR1_SCK_LO 0

// ====================================================================
// encodings and counts
`define MODE_I2C 2'h2
`define CMD_START 4'hf
`define CMD_STOP 4'hd
`define BC_EIGHT 3'h0
`define BITS_EIGHT 4'h8
`define ADDR_LAST_BIT 4'h7
`define GEN_CALL 8'h00
`define RST_PIN 1'b1
`define CNT_W 12
`define SCL_BASE_CYC 12'h004

`endif

// [logic/i2c_ctrl_pkg.sv]
// types of the i2c bus mode controller
`default_nettype none
`include "i2c_ctrl_defs.svh"
package i2c_ctrl_pkg;

  // master clock generator states
  typedef enum logic [2:0] {
    M_IDLE, M_START, M_LOW, M_WAITH, M_HIGH, M_STOP1, M_STOP2, M_STOP3
  } mstate_t;

  // one open-drain pin as driven by the block
  typedef struct packed {
    logic o;
    logic oe;
  } od_pin_t;

  // whole state of the controller
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic [2:0] bc;
    logic ack;
    logic [2:0] sck;
    logic master_select;
    logic transmit_select;
    logic bb;
    logic pin;
    logic al;
    logic address_matched_flag;
    logic ad0;
    logic lrb;
    logic [1:0] sbim;
    logic [6:0] sa;
    logic address_match_disable;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [3:0] bitpos;
    logic seen_rise;
    logic first;
    logic addressed;
    logic addr_ack;
    logic hold;
    logic [`CNT_W-1:0] hcnt;
    logic [`CNT_W-1:0] cnt;
    mstate_t mst_st;
    logic start_pend;
    logic stop_pend;
    logic scl_oe;
    logic sda_oe;
    logic irq;
    logic ap_wr;
    logic [1:0] ap_idx;
    logic [7:0] hrdata;
  } state_t;

endpackage

`default_nettype wire

// [logic/i2c_bus_mode_controller.sv]
// i2c bus mode controller: ahb-lite registers, clock generation, arbitration, addressing
//
// The implementer's own choices: register access over AHB-Lite and the address map.
`include "i2c_ctrl_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module i2c_bus_mode_controller (
  // system
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // i2c lines
  input wire logic clock_line_pin_i,
  input wire logic data_line_pin_i,
  output var i2c_ctrl_pkg::od_pin_t clock_line_pin,
  output var i2c_ctrl_pkg::od_pin_t data_line_pin,
  // word event
  output logic serial_bus_irq
);

  // ==================================================================
  // decoding helpers

  // bits per word from the count field, zero meaning eight
  function automatic logic [3:0] word_bits(input logic [2:0] bc);
    word_bits = (bc == `BC_EIGHT) ? `BITS_EIGHT : {1'b0, bc};
  endfunction

  // half scl period in system clocks, doubling per rate step
  function automatic logic [`CNT_W-1:0] half_cycles(input logic [2:0] sck);
    half_cycles = `SCL_BASE_CYC << sck;
  endfunction

  // ==================================================================
  // state and combinational terms

  i2c_ctrl_pkg::state_t q;
  i2c_ctrl_pkg::state_t n;
  logic en;
  logic rise;
  logic fall;
  logic start_det;
  logic stop_det;
  logic taken;
  logic in_data;
  logic in_ack;
  logic engaged;
  logic word_done;
  logic addr_fall;
  logic own_match;
  logic cnt_done;
  logic hcnt_done;
  logic sda_low;
  logic [3:0] nb;
  logic [3:0] tot;
  logic [3:0] cmd;
  logic [`CNT_W-1:0] half;

  // next state of the whole block; software effects first, line events
  // afterwards so that a hardware event in the same cycle wins
  always_comb begin
    n = q;
    en = q.sbim == `MODE_I2C;
    // two-stage synchronisers plus a delay stage for edges; the first stage is never looked at
    n.scl_s1 = clock_line_pin_i;
    n.scl_s2 = q.scl_s1;
    n.scl_d = q.scl_s2;
    n.sda_s1 = data_line_pin_i;
    n.sda_s2 = q.sda_s1;
    n.sda_d = q.sda_s2;
    rise = en & q.scl_s2 & ~q.scl_d;
    fall = en & ~q.scl_s2 & q.scl_d;
    start_det = en & q.scl_s2 & q.scl_d & q.sda_d & ~q.sda_s2;
    stop_det = en & q.scl_s2 & q.scl_d & ~q.sda_d & q.sda_s2;
    nb = word_bits(q.bc);
    tot = nb + {3'h0, q.ack};
    in_data = q.bitpos < nb;
    in_ack = ~in_data;
    engaged = q.master_select | q.addressed | q.address_match_disable;
    word_done = fall & q.seen_rise & (q.bitpos == tot - 4'h1);
    addr_fall = fall & q.seen_rise & q.first & ~q.master_select & ~q.address_match_disable & (q.bitpos == `ADDR_LAST_BIT);
    own_match = (q.rx[7:1] == q.sa) | (q.rx == `GEN_CALL);
    half = half_cycles(q.sck);
    cnt_done = q.cnt >= half;
    hcnt_done = q.hcnt >= half;
    taken = hsel & hready & htrans[1] & (hsize == `HSIZE_WORD);
    cmd = hwdata[`CR2_MST:`CR2_PIN];
    n.irq = 1'b0;

    // ---------------- bus address phase: reads answer from here
    n.ap_wr = taken & hwrite;
    n.ap_idx = haddr[3:2];
    if (taken & ~hwrite) begin
      unique case (haddr[3:2])
        `IDX_CONTROL_ONE: n.hrdata = {q.bc, q.ack, 1'b0, q.sck};
        `IDX_DATA_BUFFER: begin
          n.hrdata = q.rx;
          n.pin = 1'b1;
          n.al = 1'b0;
          n.address_matched_flag = 1'b0;
        end
        `IDX_OWN_ADDRESS: n.hrdata = {q.sa, q.address_match_disable};
        `IDX_CONTROL_TWO: n.hrdata = {q.master_select, q.transmit_select, q.bb, q.pin, q.al, q.address_matched_flag, q.ad0, q.lrb};
      endcase
    end

    // ---------------- bus data phase: writes land here
    if (q.ap_wr) begin
      unique case (q.ap_idx)
        `IDX_CONTROL_ONE: begin
          n.bc = hwdata[`CR1_BC_HI:`CR1_BC_LO];
          n.ack = hwdata[`CR1_ACK];
          n.sck = hwdata[`CR1_SCK_HI:`CR1_SCK_LO];
        end
        `IDX_DATA_BUFFER: begin
          n.tx = hwdata[7:0];
          n.pin = 1'b1;
          n.al = 1'b0;
          n.address_matched_flag = 1'b0;
        end
        `IDX_OWN_ADDRESS: begin
          n.sa = hwdata[7:1];
          n.address_match_disable = hwdata[0];
        end
        `IDX_CONTROL_TWO: begin
          // write side of the shared address; busy itself tracks the line
          n.master_select = hwdata[`CR2_MST];
          n.transmit_select = hwdata[`CR2_TRX];
          n.sbim = hwdata[`CR2_SBIM_HI:`CR2_SBIM_LO];
          n.al = 1'b0;
          if (hwdata[`CR2_PIN]) begin
            n.pin = 1'b1;
          end
          if ((cmd == `CMD_START) && !q.bb) begin
            n.start_pend = 1'b1;
          end
          if ((cmd == `CMD_STOP) && q.bb) begin
            n.stop_pend = 1'b1;
          end
        end
      endcase
    end

    // ---------------- slave clock stretch: one low period after release
    if (q.hold) begin
      if (!q.pin) begin
        n.hcnt = '0;
      end else if (hcnt_done) begin
        n.hcnt = '0;
        n.hold = 1'b0;
      end else begin
        n.hcnt = q.hcnt + 1'b1;
      end
    end

    // ---------------- scl rising edge: sample, arbitrate
    if (rise) begin
      n.seen_rise = 1'b1;
      n.lrb = q.sda_s2;
      if (in_data) begin
        n.rx = {q.rx[6:0], q.sda_s2};
      end
      // only data bits we send count; the ack slot is the far side's
      if (q.master_select & q.transmit_select & in_data & (q.sda_s2 != ~q.sda_oe)) begin
        n.al = 1'b1;
        n.master_select = 1'b0;
        n.transmit_select = 1'b0;
      end
    end

    // ---------------- scl falling edge: advance the bit position
    if (fall & q.seen_rise) begin
      n.seen_rise = 1'b0;
      n.bitpos = q.bitpos + 4'h1;
      if (in_data) begin
        n.tx = {q.tx[6:0], 1'b0};
      end
    end

    // slave address byte complete: decide before the ack clock
    if (addr_fall & own_match) begin
      n.addressed = 1'b1;
      n.address_matched_flag = 1'b1;
      n.ad0 = q.rx == `GEN_CALL;
      n.transmit_select = q.rx[0];
      n.addr_ack = 1'b1;
      n.pin = 1'b0;
    end

    // word complete, ack slot included when enabled
    if (word_done) begin
      n.bitpos = 4'h0;
      n.first = 1'b0;
      n.addr_ack = 1'b0;
      if (engaged) begin
        n.pin = 1'b0;
        n.irq = 1'b1;
        n.hold = ~q.master_select;
        n.hcnt = '0;
      end
      if (q.master_select & q.first & ~q.lrb) begin
        n.transmit_select = ~q.rx[0];
      end
      if (~q.master_select & q.address_match_disable & q.first) begin
        n.address_matched_flag = 1'b1;
      end
    end

    // ---------------- start and stop seen on the bus
    if (start_det) begin
      n.bb = 1'b1;
      n.bc = `BC_EIGHT;
      n.bitpos = 4'h0;
      n.seen_rise = 1'b0;
      n.first = 1'b1;
      n.addressed = 1'b0;
      n.ad0 = 1'b0;
      n.hold = 1'b0;
    end
    if (stop_det) begin
      n.bb = 1'b0;
      n.master_select = 1'b0;
      n.transmit_select = 1'b0;
      n.addressed = 1'b0;
      n.ad0 = 1'b0;
      n.hold = 1'b0;
      n.first = 1'b0;
      n.stop_pend = 1'b0;
    end

    // ---------------- master clock generator
    n.cnt = q.cnt + 1'b1;
    unique case (q.mst_st)
      i2c_ctrl_pkg::M_IDLE: begin
        n.cnt = '0;
        if (q.start_pend & ~q.bb & en) begin
          n.mst_st = i2c_ctrl_pkg::M_START;
          n.start_pend = 1'b0;
        end
      end
      i2c_ctrl_pkg::M_START: begin
        if (cnt_done) begin
          n.cnt = '0;
          n.mst_st = i2c_ctrl_pkg::M_LOW;
        end
      end
      i2c_ctrl_pkg::M_LOW: begin
        // pending low freezes the low count, so scl stays down
        if (!q.pin) begin
          n.cnt = '0;
        end else if (cnt_done) begin
          n.cnt = '0;
          n.mst_st = q.stop_pend ? i2c_ctrl_pkg::M_STOP1 : i2c_ctrl_pkg::M_WAITH;
        end
      end
      i2c_ctrl_pkg::M_WAITH: begin
        n.cnt = '0;
        if (q.scl_s2) begin
          n.mst_st = i2c_ctrl_pkg::M_HIGH;
        end
      end
      i2c_ctrl_pkg::M_HIGH: begin
        if (!q.scl_s2) begin
          n.cnt = '0;
          n.mst_st = i2c_ctrl_pkg::M_LOW;
        end else if (cnt_done) begin
          n.cnt = '0;
          n.mst_st = i2c_ctrl_pkg::M_LOW;
        end
      end
      i2c_ctrl_pkg::M_STOP1: begin
        if (cnt_done) begin
          n.cnt = '0;
          n.mst_st = i2c_ctrl_pkg::M_STOP2;
        end
      end
      i2c_ctrl_pkg::M_STOP2: begin
        if (!q.scl_s2) begin
          n.cnt = '0;
        end else if (cnt_done) begin
          n.cnt = '0;
          n.mst_st = i2c_ctrl_pkg::M_STOP3;
        end
      end
      i2c_ctrl_pkg::M_STOP3: n.cnt = '0;
    endcase
    // losing master role stops all clock output at once
    if (!n.master_select | !en) begin
      n.mst_st = i2c_ctrl_pkg::M_IDLE;
      n.start_pend = 1'b0;
      n.stop_pend = 1'b0;
    end

    // ---------------- pin drive, registered to keep the pins glitch free
    sda_low = 1'b0;
    if (q.mst_st inside {i2c_ctrl_pkg::M_START, i2c_ctrl_pkg::M_STOP1, i2c_ctrl_pkg::M_STOP2}) begin
      sda_low = 1'b1;
    end else if (q.mst_st == i2c_ctrl_pkg::M_STOP3) begin
      // scl is high here: letting sda rise is the stop itself
      sda_low = 1'b0;
    end else if (engaged & q.bb) begin
      if (in_data) begin
        sda_low = q.transmit_select & ~q.tx[7];
      end else begin
        sda_low = q.addr_ack | ~q.transmit_select;
      end
    end
    n.sda_oe = en & sda_low;
    n.scl_oe = en & ((q.mst_st inside {i2c_ctrl_pkg::M_LOW, i2c_ctrl_pkg::M_STOP1}) | q.hold);
  end

  // ==================================================================
  // state register; ce low freezes everything, synchronisers too
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.pin <= `RST_PIN;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_d <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_d <= 1'b1;
    end else if (ce) begin
      q <= n;
    end
  end

  // ==================================================================
  // outputs; zero wait states, so hready never stretches
  assign hrdata = {24'h000000, q.hrdata};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign clock_line_pin = '{o: 1'b0, oe: q.scl_oe};
  assign data_line_pin = '{o: 1'b0, oe: q.sda_oe};
  assign serial_bus_irq = q.irq;

  // ==================================================================
  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_start;
    ce && start_det;
  endsequence

  sequence s_stop;
    ce && stop_det;
  endsequence

  sequence s_lost;
    ce && rise && q.master_select && q.transmit_select && in_data && (q.sda_s2 != ~q.sda_oe);
  endsequence

  sequence s_released_high;
    q.mst_st == i2c_ctrl_pkg::M_WAITH ##1 q.mst_st == i2c_ctrl_pkg::M_HIGH;
  endsequence

  a_start_count_busy: assert property (s_start |=> (q.bc == `BC_EIGHT) && q.bb && q.first)
    else $error("start did not force count or set busy");

  a_stop_clears_roles: assert property (s_stop |=> !q.master_select && !q.transmit_select && !q.bb)
    else $error("stop did not clear master, transmit or busy");

  a_arb_lost_role: assert property (s_lost |=> q.al && !q.master_select && !q.transmit_select && q.mst_st == i2c_ctrl_pkg::M_IDLE)
    else $error("arbitration loss not handled");

  a_word_pending: assert property ((ce && word_done && engaged) |=> !q.pin && q.irq ##1 !q.irq || !ce)
    else $error("word end did not clear pending or pulse interrupt");

  a_hold_scl_low: assert property ((ce && en && q.hold && !q.pin) |=> q.scl_oe)
    else $error("scl not held low while pending is low");

  a_buffer_access: assert property ((ce && taken && !hwrite && haddr[3:2] == `IDX_DATA_BUFFER
                                     && !word_done && !addr_fall && !rise) |=> q.pin && !q.al && !q.address_matched_flag)
    else $error("buffer read did not set pending and clear flags");

  a_ctrl_two_clear: assert property ((ce && q.ap_wr && q.ap_idx == `IDX_CONTROL_TWO && !rise) |=> !q.al)
    else $error("control_two write did not clear lost flag");

  a_slave_match: assert property ((ce && addr_fall && own_match && !stop_det)
                                  |=> q.addressed && q.address_matched_flag && !q.pin && (q.transmit_select == q.rx[0]))
    else $error("slave address match not applied");

  a_master_dir: assert property ((ce && word_done && q.master_select && q.first && !q.lrb && !stop_det)
                                 |=> q.transmit_select == !q.rx[0])
    else $error("master transmit select not inverted after ack");

  a_ack_drive: assert property ((ce && en && q.bb && engaged && in_ack && !q.transmit_select) |=> q.sda_oe)
    else $error("receiver did not pull sda low in ack slot");

  a_high_wait: assert property (s_released_high |-> $past(q.scl_s2))
    else $error("high count began before scl was high");

  a_stretch_reset: assert property ((ce && q.master_select && q.mst_st == i2c_ctrl_pkg::M_HIGH && !q.scl_s2)
                                    |=> q.mst_st == i2c_ctrl_pkg::M_LOW && q.cnt == '0)
    else $error("scl pulled low did not restart the low phase");

  a_start_request: assert property ((ce && q.ap_wr && q.ap_idx == `IDX_CONTROL_TWO
                                     && hwdata[`CR2_MST:`CR2_PIN] == `CMD_START && !q.bb && !start_det)
                                    |=> q.master_select && q.start_pend)
    else $error("start command not latched");

endmodule // i2c_bus_mode_controller

`default_nettype wire

// [dv/i2c_far_slave.sv]
// far side model: addressed i2c slave with ack, clock stretch and a data-line jammer
`timescale 1ns/1ps
`default_nettype none
module i2c_far_slave #(
  parameter logic [6:0] ADDR = 7'h2c
) (
  // wire levels
  input wire logic scl,
  input wire logic sda,
  // scenario controls
  input wire logic jam,
  input wire logic stretch,
  // open-drain pulls, high pulls the line low
  output logic scl_oe,
  output logic sda_oe
);
  int rises = 0;
  int nbit = 0;
  logic [8:0] shreg = 9'h000;
  logic ack_oe = 1'b0;
  logic jam_on = 1'b0;
  realtime t_last = 0.0;
  realtime gap = 0.0;

  initial scl_oe = 1'b0;

  // =====================================================
  // start restarts the word count
  always @(negedge sda) begin
    if (scl === 1'b1) nbit = 0;
  end

  // sample on rise, keep the spacing of the last two rises
  always @(posedge scl) begin
    rises++;
    nbit++;
    shreg = {shreg[7:0], sda};
    gap = $realtime - t_last;
    t_last = $realtime;
  end

  // ack the matching address in the ninth slot; only the first word after start
  always @(negedge scl) begin
    ack_oe <= (nbit == 8) && (shreg[7:1] == ADDR);
    if (jam && nbit == 0) jam_on <= 1'b1;
    if (stretch) begin
      // a slow device holds the clock low well past the master's own low half
      scl_oe <= 1'b1;
      #2000 scl_oe <= 1'b0;
    end
  end

  // letting go of the jammed line while scl is high makes a stop
  always @(negedge jam) jam_on <= 1'b0;

  assign sda_oe = ack_oe | jam_on;
endmodule // i2c_far_slave
`default_nettype wire

// [dv/i2c_bus_mode_controller_tb_top.sv]
// testbench of the i2c bus mode controller: registers, master words, stop, arbitration
`include "i2c_ctrl_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_mode_controller_tb_top;
  // =====================================================
  // addresses and the far side address
  localparam logic [31:0] A_CR1 = {28'h0, `IDX_CONTROL_ONE, 2'h0};
  localparam logic [31:0] A_DBR = {28'h0, `IDX_DATA_BUFFER, 2'h0};
  localparam logic [31:0] A_OWN = {28'h0, `IDX_OWN_ADDRESS, 2'h0};
  localparam logic [31:0] A_CR2 = {28'h0, `IDX_CONTROL_TWO, 2'h0};
  localparam logic [6:0] P_ADDR = 7'h2c;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic jam = 1'b0;
  logic stretch = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  i2c_ctrl_pkg::od_pin_t scl_pin;
  i2c_ctrl_pkg::od_pin_t sda_pin;
  logic p_scl_oe;
  logic p_sda_oe;
  logic scl_w;
  logic sda_w;
  int n_fail = 0;
  int comparisons = 0;

  // wired-and lines with pull-ups
  assign scl_w = ~(scl_pin.oe | p_scl_oe);
  assign sda_w = ~(sda_pin.oe | p_sda_oe);

  initial begin
    forever #50 hclk = ~hclk;
  end

  i2c_bus_mode_controller i_i2c_bus_mode_controller (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .clock_line_pin_i(scl_w), .data_line_pin_i(sda_w),
    .clock_line_pin(scl_pin), .data_line_pin(sda_pin), .serial_bus_irq(irq)
  );

  i2c_far_slave #(.ADDR(P_ADDR)) i_i2c_far_slave (
    .scl(scl_w), .sda(sda_w), .jam(jam), .stretch(stretch), .scl_oe(p_scl_oe), .sda_oe(p_sda_oe)
  );

  // =====================================================
  // reporting
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_up(input string what);
    n_fail++;
    $display("mismatch %s expected done seen timeout", what);
    print_verdict();
  endtask

  // =====================================================
  // one ahb-lite single word transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] d, output logic [7:0] r);
    int k;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    k = 0;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 20);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 40);
    r = hrdata[7:0];
    if (k >= 40) give_up("bus answer");
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdchk(input string what, input logic [31:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] x;
    bus(1'b0, a, 8'h00, x);
    chk(what, {24'h0, e}, {24'h0, x & m});
  endtask

  // polls status until the masked bits reach a value; a slow bus must not hang the run
  task automatic poll(input string what, input logic [7:0] m, input logic [7:0] v);
    logic [7:0] x;
    int k;
    for (k = 0; k < 200; k++) begin
      bus(1'b0, A_CR2, 8'h00, x);
      if ((x & m) === v) break;
    end
    if (k >= 200) give_up(what);
  endtask

  task automatic wait_irq(input string what);
    int k;
    for (k = 0; k < 3000; k++) begin
      @(negedge hclk);
      if (irq === 1'b1) break;
    end
    if (k >= 3000) give_up(what);
    @(posedge hclk);
  endtask

  // =====================================================
  // scenarios
  task automatic t_regs();
    rdchk("status after reset", A_CR2, 8'hff, 8'h10);
    wr(A_CR1, 8'hff);
    rdchk("control_one", A_CR1, 8'hff, 8'hf7);
    rdchk("control_one alias", A_CR1 + 32'h10, 8'hff, 8'hf7);
    hsize <= 3'h0; // a byte-size write must be ignored
    wr(A_CR1, 8'h00);
    hsize <= 3'h2;
    rdchk("control_one after byte write", A_CR1, 8'hff, 8'hf7);
    wr(A_OWN, 8'ha2);
    rdchk("own_address_reg", A_OWN, 8'hff, 8'ha2);
    chk("lines idle", 32'h3, {30'h0, scl_w, sda_w});
    wr(A_CR2, 8'h18);
    rdchk("status in i2c mode", A_CR2, 8'hff, 8'h10);
    $display("test registers done");
  endtask

  task automatic t_start();
    int n0;
    wr(A_CR1, 8'h30);
    wr(A_DBR, {P_ADDR, 1'b0});
    n0 = i_i2c_far_slave.rises;
    wr(A_CR2, 8'hf8);
    wait_irq("address word");
    chk("address clocks", 32'd9, i_i2c_far_slave.rises - n0);
    chk("address byte", {24'h0, P_ADDR, 1'b0}, {24'h0, i_i2c_far_slave.shreg[8:1]});
    chk("scl period", 32'h1, {31'h0, i_i2c_far_slave.gap >= 800.0 && i_i2c_far_slave.gap <= 1400.0});
    rdchk("status after address", A_CR2, 8'hff, 8'he0);
    rdchk("bit count after start", A_CR1, 8'hff, 8'h10);
    $display("test start done");
  endtask

  task automatic t_data();
    int n0;
    wr(A_CR1, 8'h00);
    stretch <= 1'b1;
    n0 = i_i2c_far_slave.rises;
    wr(A_DBR, 8'h5a);
    rdchk("status after buffer write", A_CR2, 8'hff, 8'hf0);
    wait_irq("data word");
    chk("data clocks", 32'd8, i_i2c_far_slave.rises - n0);
    chk("data byte", 32'h5a, {24'h0, i_i2c_far_slave.shreg[7:0]});
    chk("stretched period", 32'h1, {31'h0, i_i2c_far_slave.gap >= 2400.0});
    rdchk("status after data", A_CR2, 8'hff, 8'he0);
    stretch <= 1'b0;
    $display("test data done");
  endtask

  task automatic t_stop();
    wr(A_CR2, 8'hd8);
    poll("bus free after stop", 8'h20, 8'h00);
    rdchk("status after stop", A_CR2, 8'hfe, 8'h10);
    $display("test stop done");
  endtask

  task automatic t_arb();
    wr(A_CR1, 8'h10);
    wr(A_DBR, 8'hff);
    jam <= 1'b1;
    wr(A_CR2, 8'hf8);
    poll("lost flag", 8'h08, 8'h08);
    rdchk("status on loss", A_CR2, 8'he8, 8'h28);
    chk("sda released", 32'h0, {31'h0, sda_pin.oe});
    jam <= 1'b0;
    poll("bus free after far stop", 8'h20, 8'h00);
    rdchk("mode after far stop", A_CR2, 8'hc0, 8'h00);
    wr(A_CR2, 8'h18);
    rdchk("lost flag cleared", A_CR2, 8'hfe, 8'h10);
    $display("test arbitration done");
  endtask

  // =====================================================
  // main sequence
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_start();
    t_data();
    t_stop();
    t_arb();
    print_verdict();
  end
endmodule // i2c_bus_mode_controller_tb_top
`default_nettype wire
